// ===== bench/tbrc_slow_source.sv
`timescale 1ns/10ps
// Far-side clock sources: external slow clock and crystal oscillator
module tbrc_slow_source #(
   parameter int HALF_NS = 15259, // Half period, near 32.768 kHz
   parameter int SKEW_NS = 7630 // Crystal lags a quarter period
)(
   output logic slow_ref_in, // External slow clock pin
   output logic crystal_in // Crystal oscillator level
);

   // Slow clock runs free, it is a board oscillator
   initial
   begin
      slow_ref_in = 1'b0;
      forever #(HALF_NS) slow_ref_in = ~slow_ref_in;
   end

   // Crystal in quadrature, so a wrong source pick in the slow clock test shows up as a mismatch
   initial
   begin
      crystal_in = 1'b1;
      #(SKEW_NS);
      forever
      begin
         crystal_in = ~crystal_in;
         #(HALF_NS);
      end
   end

endmodule

// ===== bench/timebase_and_reset_control_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the timebase and reset control block
module timebase_and_reset_control_tb;

   logic ref_clk, rst, reset_pin_n, supply_ok, cmd_reset, cmd_clock_we, cmd_halt_we; // Stimulus
   logic [7:0] cmd_clock_data, cmd_halt_data; // Command bytes
   logic key_event, bus_start, encoder_change, encoder_enable; // Wake sources
   logic slow_ref_in, crystal_in, scan_line_eight_in, scan_line_eight_oe_in; // Pins
   logic core_reset, proc_tick, proc_clk, pwm_timebase, halted; // Observed
   logic [7:0] timebase_select; // Config contents
   logic buffered_timebase_out, buffered_timebase_oe, crystal_out, crystal_out_oe; // Pin side
   int bad_count = 0; // Mismatches
   int comparisons = 0; // Checks made
   int n; // Cycle counter
   time t0; // Edge timestamp

   tbrc_timebase_ctrl dut (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
      .supply_ok(supply_ok), .cmd_reset(cmd_reset), .cmd_clock_we(cmd_clock_we),
      .cmd_clock_data(cmd_clock_data), .cmd_halt_we(cmd_halt_we), .cmd_halt_data(cmd_halt_data),
      .key_event(key_event), .bus_start(bus_start), .encoder_change(encoder_change),
      .encoder_enable(encoder_enable), .slow_ref_in(slow_ref_in), .crystal_in(crystal_in),
      .scan_line_eight_in(scan_line_eight_in), .scan_line_eight_oe_in(scan_line_eight_oe_in),
      .core_reset(core_reset), .proc_tick(proc_tick), .proc_clk(proc_clk),
      .pwm_timebase(pwm_timebase), .halted(halted), .timebase_select(timebase_select),
      .buffered_timebase_out(buffered_timebase_out), .buffered_timebase_oe(buffered_timebase_oe),
      .crystal_out(crystal_out), .crystal_out_oe(crystal_out_oe));

   tbrc_slow_source src (.slow_ref_in(slow_ref_in), .crystal_in(crystal_in));

   // 25 MHz reference clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Verdict and end of run, shared with the watchdog
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Wait whole cycles, inputs move only at falling edges
   task automatic tick(input int cnt);
      repeat (cnt) @(negedge ref_clk);
   endtask

   // One-cycle command strobes
   task automatic write_clock(input logic [7:0] d);
      @(negedge ref_clk);
      cmd_clock_we = 1'b1;
      cmd_clock_data = d;
      @(negedge ref_clk);
      cmd_clock_we = 1'b0;
   endtask

   task automatic write_halt(input logic [7:0] d);
      @(negedge ref_clk);
      cmd_halt_we = 1'b1;
      cmd_halt_data = d;
      @(negedge ref_clk);
      cmd_halt_we = 1'b0;
   endtask

   // Pulse: 0 key, 1 bus start, 2 encoder, 3 reset command
   task automatic pulse(input int sel);
      @(negedge ref_clk);
      case (sel)
         0: key_event = 1'b1;
         1: bus_start = 1'b1;
         2: encoder_change = 1'b1;
         default: cmd_reset = 1'b1;
      endcase
      @(negedge ref_clk);
      {key_event, bus_start, encoder_change, cmd_reset} = 4'h0;
   endtask

   // Bounded wait for the internal reset to drop, cycles counted in n
   task automatic wait_release(input int limit);
      n = 0;
      while (core_reset !== 1'b0 && n < limit)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   // Bounded wait for halt entry, cycles counted in n
   task automatic wait_halt;
      n = 0;
      while (halted !== 1'b1 && n < 2000)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   // Timebase and pin must track the chosen source, high then low
   task automatic check_follow(input logic use_slow);
      if (use_slow) @(posedge slow_ref_in); else @(posedge crystal_in);
      tick(10);
      check(pwm_timebase, 1'b1);
      check(buffered_timebase_out, 1'b1);
      check(crystal_out, !crystal_in);
      if (use_slow) @(negedge slow_ref_in); else @(negedge crystal_in);
      tick(10);
      check(pwm_timebase, 1'b0);
      check(buffered_timebase_out, 1'b0);
   endtask

   // Watchdog, several times the expected run length
   initial
   begin
      repeat (80000) @(posedge ref_clk);
      bad_count++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      {reset_pin_n, supply_ok, scan_line_eight_in, scan_line_eight_oe_in} = 4'hf;
      {cmd_reset, cmd_clock_we, cmd_halt_we, key_event, bus_start, encoder_change} = 6'h0;
      encoder_enable = 1'b1;
      cmd_clock_data = 8'h00;
      cmd_halt_data = 8'h00;
      tick(4);
      rst = 1'b0;
      // Power-on countdown of 256 before release
      wait_release(400);
      check(n >= 256 && n <= 270, 1'b1);
      check(timebase_select, 8'h00);
      check(buffered_timebase_oe, 1'b1);
      // Processing tick every 12 clocks, clock high half of it
      while (proc_tick !== 1'b1) @(negedge ref_clk);
      n = 0;
      tick(1);
      while (proc_tick !== 1'b1 && n < 20)
      begin
         n += proc_clk;
         @(negedge ref_clk);
      end
      check(16'(n), 16'h6);
      // Internal timebase is processing clock over 64
      @(posedge pwm_timebase);
      t0 = $time;
      @(posedge pwm_timebase);
      check(16'(($time - t0) / 40), 16'h300);
      // Reserved bits read back as zero
      write_clock(8'hff);
      tick(1);
      check(timebase_select, 8'h4b);
      // External clock, buffer on, crystal driver off
      tick(2);
      check(buffered_timebase_oe, 1'b1);
      check(crystal_out_oe, 1'b0);
      check_follow(1'b1);
      // Crystal source, buffer on; one write per initialisation
      pulse(3);
      wait_release(60);
      write_clock(8'h43);
      tick(2);
      check(crystal_out_oe, 1'b1);
      check_follow(1'b0);
      // Buffer off, shared pin goes back to the scanner
      scan_line_eight_oe_in = 1'b0;
      scan_line_eight_in = 1'b0;
      pulse(3);
      wait_release(60);
      write_clock(8'h0b);
      tick(3);
      check(buffered_timebase_oe, 1'b0);
      check(buffered_timebase_out, 1'b0);
      // Reset pin: held 720 ns, quick entry, bounded exit
      pulse(3);
      wait_release(60);
      write_clock(8'h4b);
      reset_pin_n = 1'b0;
      tick(3);
      check(core_reset, 1'b1);
      write_clock(8'h4b);
      tick(13);
      reset_pin_n = 1'b1;
      wait_release(60);
      check(n <= 35, 1'b1);
      check(timebase_select, 8'h00);
      // Reset command clears the configuration
      write_clock(8'h40);
      pulse(3);
      check(core_reset, 1'b1);
      wait_release(60);
      check(timebase_select, 8'h00);
      // Supply loss: writes refused, full countdown again
      supply_ok = 1'b0;
      tick(5);
      check(core_reset, 1'b1);
      write_clock(8'h4b);
      supply_ok = 1'b1;
      wait_release(400);
      check(n >= 256 && n <= 270, 1'b1);
      check(timebase_select, 8'h00);
      // Halt after one idle period, then each wake source
      write_halt(8'h01);
      for (int i = 0; i < 4; i++)
      begin
         encoder_enable = (i != 3);
         wait_halt();
         check(halted, 1'b1);
         n = 0;
         repeat (24)
         begin
            @(negedge ref_clk);
            n += proc_tick;
         end
         check(16'(n), 16'h0);
         pulse(i > 2 ? 2 : i);
         tick(1);
         check(halted, i == 3);
      end
      pulse(0);
      tick(13);
      check(halted, 1'b0);
      // Reset pin also wakes from halt
      wait_halt();
      check(halted, 1'b1);
      reset_pin_n = 1'b0;
      tick(3);
      check(halted, 1'b0);
      tick(15);
      reset_pin_n = 1'b1;
      wait_release(60);
      check(n <= 35, 1'b1);
      stop_test();
   end

endmodule

// ===== src/tbrc_pkg.sv
package tbrc_pkg;

   // Clock rates, in their own units
   localparam int CLK_KHZ = 25000; // Reference clock, 40 ns period
   localparam int PROC_KHZ = 2000; // Processing clock target
   localparam int PROC_DIV = CLK_KHZ / PROC_KHZ; // Cycles per processing tick
   localparam logic [3:0] PROC_LAST = 4'(PROC_DIV - 1); // Divider wrap value
   localparam logic [3:0] PROC_HALF = 4'(PROC_DIV / 2); // High phase length
   localparam int PWM_DIV = 64; // Processing ticks per PWM period
   localparam logic [5:0] PWM_LAST = 6'(PWM_DIV - 1); // Prescaler wrap value

   // Reset timing
   localparam int EXIT_NS = 1400; // Longest release time after pin goes high
   localparam int SYNC_LAT = 4; // Synchroniser plus state hand-off latency
   localparam int EXIT_CYC = (EXIT_NS * CLK_KHZ) / 1000000 - SYNC_LAT; // Round down
   localparam logic [5:0] EXIT_LOAD = 6'(EXIT_CYC); // Release counter preload
   localparam logic [7:0] POR_PRELOAD = 8'hff; // Power-on countdown preload

   // Clock configuration byte layout
   localparam int BUF_EN_BIT = 6; // Buffered timebase output enable
   localparam int EXT_SEL_BIT = 3; // 0 crystal, 1 external clock
   localparam int SRC_LSB = 0; // PWM source field low bit
   localparam int SRC_MSB = 1; // PWM source field high bit
   localparam logic [1:0] SRC_INTERNAL = 2'h0; // Prescaled internal clock
   localparam logic [1:0] SRC_EXTERNAL = 2'h3; // External clock or crystal
   localparam logic [7:0] CFG_MASK = 8'h4b; // Writable bits
   localparam logic [7:0] CFG_RESET = 8'h00; // Default after any reset

   // Inactivity period, in PWM periods
   localparam logic [7:0] HALT_RESET = 8'h10; // Default idle period

   // Reset sequencer states
   typedef enum logic [1:0]
   {
      TBRC_POR = 2'b00,
      TBRC_HOLD = 2'b01,
      TBRC_RUN = 2'b10
   } tbrc_rst_type;

endpackage

// ===== src/tbrc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module tbrc_sync #(
   parameter int WIDTH = 1 // Number of bits
)(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Asynchronous reset
   input wire logic [WIDTH-1:0] d, // Asynchronous inputs
   output logic [WIDTH-1:0] q // Synchronised outputs
);

   logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage

   // Both stages clear to zero; callers treat zero as the safe level
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

// ===== src/tbrc_timebase_ctrl.sv
`timescale 1ns/10ps
module tbrc_timebase_ctrl (
   input wire logic ref_clk, // System clock, 25 MHz
   input wire logic rst, // Asynchronous power reset, high
   input wire logic reset_pin_n, // External reset pin, low active
   input wire logic supply_ok, // Supply above power-on threshold
   input wire logic cmd_reset, // Host reset command pulse
   input wire logic cmd_clock_we, // Clock configuration write pulse
   input wire logic [7:0] cmd_clock_data, // Clock configuration byte
   input wire logic cmd_halt_we, // Idle period write pulse
   input wire logic [7:0] cmd_halt_data, // Idle period in PWM periods
   input wire logic key_event, // Key press or release pulse
   input wire logic bus_start, // Bus start condition pulse
   input wire logic encoder_change, // Encoder counter change pulse
   input wire logic encoder_enable, // Encoder interface enabled
   input wire logic slow_ref_in, // External slow clock pin
   input wire logic crystal_in, // Crystal oscillator input pin
   input wire logic scan_line_eight_in, // Scanner drive for shared pin
   input wire logic scan_line_eight_oe_in, // Scanner enable for shared pin
   output logic core_reset, // Internal reset to other blocks
   output logic proc_tick, // One-cycle processing tick
   output logic proc_clk, // Processing clock square wave
   output logic pwm_timebase, // Selected PWM timebase level
   output logic halted, // Halt mode indicator
   output logic [7:0] timebase_select, // Clock configuration contents
   output logic buffered_timebase_out, // Shared pin output value
   output logic buffered_timebase_oe, // Shared pin output enable
   output logic crystal_out, // Crystal oscillator feedback pin
   output logic crystal_out_oe // Crystal feedback enable
);

   localparam int exit_bound = tbrc_pkg::EXIT_CYC + 2; // Pin release bound
   localparam int por_bound = 258; // Countdown plus hand-off

   // Synchronised pins
   logic [3:0] pins_s; // Reset pin, supply, slow clock, crystal
   logic reset_pin_s; // Synchronised reset pin
   logic supply_s; // Synchronised supply flag
   logic slow_s; // Synchronised slow clock
   logic crystal_s; // Synchronised crystal input

   // Reset sequencer
   tbrc_pkg::tbrc_rst_type state_reg; // Current reset state
   tbrc_pkg::tbrc_rst_type state_next; // Next reset state
   logic [7:0] por_cnt_reg; // Power-on countdown
   logic [7:0] por_cnt_next; // Next countdown value
   logic [5:0] exit_cnt_reg; // Release delay after pin or command
   logic [5:0] exit_cnt_next; // Next release delay
   logic ext_low; // Pin reset requested
   logic reset_req; // Pin or command reset

   // Clocks and halt
   logic [3:0] div_cnt_reg; // Processing divider
   logic [5:0] pre_cnt_reg; // PWM prescaler
   logic [7:0] idle_cnt_reg; // PWM periods without activity
   logic [7:0] halt_period_reg; // Programmed idle period
   logic halted_reg; // Halt mode
   logic run_clk; // Divider allowed to run
   logic div_wrap; // Divider at last count
   logic pre_wrap; // Prescaler end of period
   logic wake; // Any wake event
   logic idle_expired; // Idle period reached

   // Configuration and outputs
   logic [7:0] cfg_reg; // Clock configuration register
   logic [1:0] src_sel; // PWM source field
   logic buf_en; // Buffer enable field
   logic ext_sel; // External timebase select field
   logic internal_tb; // Prescaled internal timebase
   logic external_tb; // Crystal or slow clock timebase
   logic timebase_next; // Selected timebase
   logic tb_reg; // Registered timebase
   logic proc_clk_reg; // Registered processing clock
   logic pin_out_reg; // Registered shared pin value
   logic pin_oe_reg; // Registered shared pin enable
   logic xout_reg; // Registered crystal feedback

   // Every pin crosses two flops before use
   tbrc_sync #(
      .WIDTH(4)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({reset_pin_n, supply_ok, slow_ref_in, crystal_in}),
      .q(pins_s)
   );

   assign reset_pin_s = pins_s[3];
   assign supply_s = pins_s[2];
   assign slow_s = pins_s[1];
   assign crystal_s = pins_s[0];

   // Reset sources and state decode
   assign ext_low = ~reset_pin_s;
   assign reset_req = ext_low | cmd_reset;
   // The pin term bypasses the state so ports reset the same cycle
   assign core_reset = (state_reg != tbrc_pkg::TBRC_RUN) | ext_low;

   // Next state of the reset sequencer
   always_comb
   begin
      state_next = state_reg;
      por_cnt_next = por_cnt_reg;
      exit_cnt_next = exit_cnt_reg;
      unique case (state_reg)
         tbrc_pkg::TBRC_POR:
         begin
            // Hold and preload while supply is low; underflow releases reset
            if (!supply_s)
               por_cnt_next = tbrc_pkg::POR_PRELOAD;
            else if (por_cnt_reg == 8'h00)
               state_next = tbrc_pkg::TBRC_RUN;
            else
               por_cnt_next = por_cnt_reg - 8'h01;
         end
         tbrc_pkg::TBRC_HOLD:
         begin
            // Restart the delay while a source persists
            if (!supply_s)
            begin
               state_next = tbrc_pkg::TBRC_POR;
               por_cnt_next = tbrc_pkg::POR_PRELOAD;
            end
            else if (reset_req)
               exit_cnt_next = tbrc_pkg::EXIT_LOAD;
            else if (exit_cnt_reg == 6'h00)
               state_next = tbrc_pkg::TBRC_RUN;
            else
               exit_cnt_next = exit_cnt_reg - 6'h01;
         end
         tbrc_pkg::TBRC_RUN:
         begin
            // Brown-out falls back to power-on sequence
            if (!supply_s)
            begin
               state_next = tbrc_pkg::TBRC_POR;
               por_cnt_next = tbrc_pkg::POR_PRELOAD;
            end
            else if (reset_req)
            begin
               state_next = tbrc_pkg::TBRC_HOLD;
               exit_cnt_next = tbrc_pkg::EXIT_LOAD;
            end
         end
         default:
         begin
            state_next = tbrc_pkg::TBRC_POR;
            por_cnt_next = tbrc_pkg::POR_PRELOAD;
         end
      endcase
   end

   // Reset sequencer registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= tbrc_pkg::TBRC_POR;
         por_cnt_reg <= tbrc_pkg::POR_PRELOAD;
         exit_cnt_reg <= tbrc_pkg::EXIT_LOAD;
      end
      else
      begin
         state_reg <= state_next;
         por_cnt_reg <= por_cnt_next;
         exit_cnt_reg <= exit_cnt_next;
      end
   end

   // Host writes; reserved bits always stored as zero
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg <= tbrc_pkg::CFG_RESET;
         halt_period_reg <= tbrc_pkg::HALT_RESET;
      end
      else if (core_reset)
      begin
         cfg_reg <= tbrc_pkg::CFG_RESET;
         halt_period_reg <= tbrc_pkg::HALT_RESET;
      end
      else
      begin
         // Later writes are accepted; the host is expected to write once
         if (cmd_clock_we)
            cfg_reg <= cmd_clock_data & tbrc_pkg::CFG_MASK;
         if (cmd_halt_we)
            halt_period_reg <= cmd_halt_data;
      end
   end

   // Field decode
   assign buf_en = cfg_reg[tbrc_pkg::BUF_EN_BIT];
   assign ext_sel = cfg_reg[tbrc_pkg::EXT_SEL_BIT];
   assign src_sel = cfg_reg[tbrc_pkg::SRC_MSB:tbrc_pkg::SRC_LSB];
   assign timebase_select = cfg_reg;

   // Halt and wake decode
   assign wake = key_event | bus_start | (encoder_change & encoder_enable);
   assign run_clk = ~core_reset & ~halted_reg;
   assign div_wrap = div_cnt_reg == tbrc_pkg::PROC_LAST;
   assign proc_tick = run_clk & div_wrap;
   assign pre_wrap = proc_tick & (pre_cnt_reg == tbrc_pkg::PWM_LAST);
   assign idle_expired = (halt_period_reg != 8'h00) & (idle_cnt_reg == halt_period_reg);
   assign halted = halted_reg;

   // Processing divider, frozen in halt; ref_clk is the system clock
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         div_cnt_reg <= 4'h0;
      else if (core_reset)
         div_cnt_reg <= 4'h0;
      else if (run_clk)
         div_cnt_reg <= div_wrap ? 4'h0 : div_cnt_reg + 4'h1;

   // PWM prescaler counts processing ticks
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         pre_cnt_reg <= 6'h00;
      else if (core_reset)
         pre_cnt_reg <= 6'h00;
      else if (proc_tick)
         pre_cnt_reg <= pre_cnt_reg + 6'h01;

   // Inactivity counter and halt flag; a wake beats a halt entry
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         idle_cnt_reg <= 8'h00;
         halted_reg <= 1'b0;
      end
      else if (core_reset || wake || cmd_clock_we || cmd_halt_we)
      begin
         idle_cnt_reg <= 8'h00;
         halted_reg <= 1'b0;
      end
      else if (idle_expired)
         halted_reg <= 1'b1;
      else if (pre_wrap)
         idle_cnt_reg <= idle_cnt_reg + 8'h01;

   // Timebase sources and selection; reserved codes fall back to internal
   assign internal_tb = pre_cnt_reg[5];
   assign external_tb = ext_sel ? slow_s : crystal_s;
   assign timebase_next = (src_sel == tbrc_pkg::SRC_EXTERNAL) ? external_tb : internal_tb;

   // Registered clock outputs and shared pin
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tb_reg <= 1'b0;
         proc_clk_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         xout_reg <= 1'b1;
      end
      else
      begin
         tb_reg <= timebase_next;
         proc_clk_reg <= run_clk & ~idle_expired & (div_cnt_reg < tbrc_pkg::PROC_HALF);
         // Buffer owns the pin; scanner and port lose it meanwhile
         pin_out_reg <= buf_en ? timebase_next : scan_line_eight_in;
         pin_oe_reg <= buf_en | scan_line_eight_oe_in;
         xout_reg <= ~crystal_s;
      end
   end

   assign pwm_timebase = tb_reg;
   assign proc_clk = proc_clk_reg;
   assign buffered_timebase_out = pin_out_reg;
   assign buffered_timebase_oe = pin_oe_reg;
   assign crystal_out = xout_reg;
   // Feedback only driven when a crystal is fitted
   assign crystal_out_oe = ~ext_sel;

   // Checks
   a_cfg_reset_default: assert property (@(posedge ref_clk) disable iff (rst)
      core_reset |=> cfg_reg == tbrc_pkg::CFG_RESET)
      else $error("config not defaulted after reset");
   a_reserved_bits_zero: assert property (@(posedge ref_clk) disable iff (rst)
      cmd_clock_we && !core_reset |=> cfg_reg == ($past(cmd_clock_data) & tbrc_pkg::CFG_MASK))
      else $error("config write stored wrong value");
   a_buffer_drives_pin: assert property (@(posedge ref_clk) disable iff (rst)
      buf_en |=> buffered_timebase_oe && buffered_timebase_out == $past(timebase_next))
      else $error("buffer does not own shared pin");
   a_scan_pass_through: assert property (@(posedge ref_clk) disable iff (rst)
      !buf_en |=> buffered_timebase_oe == $past(scan_line_eight_oe_in))
      else $error("scanner lost pin with buffer off");
   a_source_external: assert property (@(posedge ref_clk) disable iff (rst)
      src_sel == tbrc_pkg::SRC_EXTERNAL && ext_sel |=> pwm_timebase == $past(slow_s))
      else $error("external source not selected");
   a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
      proc_tick |=> !proc_tick [*8])
      else $error("processing ticks too close");
   a_halt_stops_clk: assert property (@(posedge ref_clk) disable iff (rst)
      halted_reg |-> !proc_tick && !$rose(proc_clk))
      else $error("processing clock runs in halt");
   a_wake_clears_halt: assert property (@(posedge ref_clk) disable iff (rst)
      wake |=> !halted_reg)
      else $error("wake event ignored");
   a_pin_exit_bound: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(ext_low) && supply_s && state_reg == tbrc_pkg::TBRC_HOLD
      ##1 (!reset_req && supply_s) [*2] |-> ##[1:exit_bound] !core_reset)
      else $error("reset release too slow");
   a_por_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !supply_s |=> core_reset && por_cnt_reg == tbrc_pkg::POR_PRELOAD)
      else $error("low supply does not hold reset");
   a_por_release: assert property (@(posedge ref_clk) disable iff (rst)
      state_reg == tbrc_pkg::TBRC_POR && supply_s && por_cnt_reg == 8'h00 |=> state_reg == tbrc_pkg::TBRC_RUN)
      else $error("countdown underflow did not release");
   a_por_bounded: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(supply_s) && state_reg == tbrc_pkg::TBRC_POR |-> ##[1:por_bound] state_reg != tbrc_pkg::TBRC_POR)
      else $error("power-on countdown too long");

endmodule
